// >>> hdl/bcs_pkg.sv
// package for the boot and configuration mode sequencer
package bcs_pkg;

  localparam int unsigned CLK_HZ          = 20_000_000;
  // request toggle band, in hertz
  localparam int unsigned REQ_NOM_HZ      = 30_000;
  localparam int unsigned REQ_MIN_HZ      = 25_000;
  localparam int unsigned REQ_MAX_HZ      = 50_000;
  // half period limits in cycles: longest rounds down, least rounds up
  localparam int unsigned HALF_MAX_CYC    = CLK_HZ / (2 * REQ_MIN_HZ);
  localparam int unsigned HALF_MIN_CYC    = (CLK_HZ + 2 * REQ_MAX_HZ - 1) / (2 * REQ_MAX_HZ);
  // edges in band needed to accept a request
  localparam int unsigned REQ_EDGES       = 8;
  // observation window for the request pin, in cycles
  localparam int unsigned REQ_WINDOW_CYC  = 4 * REQ_EDGES * HALF_MAX_CYC;
  localparam int unsigned MAIN_PAGES      = 64;
  localparam logic [5:0]  ENTRY_PAGE      = 6'h00;
  localparam logic [5:0]  LAST_PAGE       = 6'h3f;
  // authentication levels
  localparam logic [1:0]  AUTH_NONE       = 2'h0;
  localparam logic [1:0]  AUTH_USER       = 2'h1;
  localparam logic [1:0]  AUTH_MFG        = 2'h2;
  // status codes
  localparam logic [7:0]  ST_OK           = 8'h00;
  localparam logic [7:0]  ST_INSUFF_AUTH  = 8'h2f;
  localparam logic [15:0] FULL_ERASE_CMD  = 16'hfd05;
  // event codes
  localparam logic [7:0]  EVT_CM_ENTERED  = 8'h01;
  localparam logic [7:0]  EVT_CMD_DONE    = 8'h02;
  localparam logic [7:0]  IRQ_CM_MASK     = 8'h03;

  // gray coded along boot path
  typedef enum logic [4:0] {
    S_INIT      = 5'h00,
    S_NVM_UP    = 5'h01,
    S_MFG_TRIM  = 5'h03,
    S_REQ_CHK   = 5'h02,
    S_MFG_LOCK  = 5'h06,
    S_USR_TRIM  = 5'h07,
    S_USR_LOCK  = 5'h05,
    S_ENTRY     = 5'h04,
    S_APP_VEC   = 5'h0c,
    S_APP_RET   = 5'h0d,
    S_APP_CAUSE = 5'h0f,
    S_APP_RUN   = 5'h0e,
    S_CM_INIT   = 5'h0a,
    S_CM_ANN    = 5'h0b,
    S_CM_AUTH   = 5'h09,
    S_CM_IDLE   = 5'h08,
    S_CM_EXEC   = 5'h18,
    S_HALT      = 5'h1f
  } bcs_state_t;

  // one nvm record with its integrity result
  typedef struct packed {
    logic [31:0] data;
    logic        ok;
  } bcs_rec_t;

  // command from the spi transport
  typedef struct packed {
    logic [15:0] opcode;
    logic [1:0]  level;
  } bcs_cmd_t;

  // event towards the spi transport
  typedef struct packed {
    logic [7:0]  code;
    logic [7:0]  status;
  } bcs_evt_t;

endpackage

// >>> hdl/bcs_sequencer.sv
// boot sequencer: rom stage, application path and configuration mode loop
`timescale 1ns/10ps

module bcs_sequencer
  import bcs_pkg::*;
#(
  parameter int unsigned WINDOW_CYC = REQ_WINDOW_CYC
) (
  // clock and reset
  input  wire logic        I_CLK,
  input  wire logic        I_RESET,
  // boot cause
  input  wire logic        i_por,
  input  wire logic        i_sleep_resume,
  // nvm records
  input  wire logic        i_nvm_ready,
  input  wire logic        i_nvm_blank,
  input  wire bcs_rec_t    i_mfg_trim,
  input  wire bcs_rec_t    i_mfg_lock,
  input  wire bcs_rec_t    i_usr_trim,
  input  wire bcs_rec_t    i_usr_lock,
  input  wire logic        i_entry_valid,
  input  wire logic        i_mfg_auth_req,
  input  wire logic        i_usr_auth_req,
  // request pin
  input  wire logic        i_config_request_pin,
  // spi transport command and event
  input  wire logic        i_cmd_valid,
  input  wire bcs_cmd_t    i_cmd,
  input  wire logic        i_cmd_exec_done,
  input  wire logic        i_task_pending,
  output logic             o_cmd_ready,
  output logic             o_cmd_start,
  output logic             o_evt_valid,
  output bcs_evt_t         o_evt,
  // applied values and status
  output logic [31:0]      o_trim_mfg,
  output logic [31:0]      o_trim_usr,
  output logic [31:0]      o_lock_mfg,
  output logic [31:0]      o_lock_usr,
  output logic             o_debug_en,
  output logic             o_configuration_mode,
  output logic             o_app_mode,
  output logic             o_nvm_stage,
  output logic             o_halt,
  output logic             o_cpu_sleep,
  output logic [7:0]       o_irq_mask,
  output logic [1:0]       o_auth_level,
  output logic [5:0]       o_exec_page,
  output logic             o_vec_in_nvm,
  output logic             o_retention_cfg,
  output logic             o_resume_path
);

  bcs_state_t  state_reg, state_next;
  logic        pin_d_reg;
  logic [15:0] half_reg;
  logic [15:0] win_reg;
  logic [4:0]  edges_reg;
  logic        req_seen_reg;
  logic        por_boot_reg;
  logic        resume_reg;

  // helper: clamp count to 16 bits
  function automatic logic [15:0] sat16(input logic [15:0] v);
    return (v == 16'hffff) ? v : v + 16'h0001;
  endfunction

  // request edge detection
  wire pin_edge   = i_config_request_pin ^ pin_d_reg;
  wire half_in_bd = (half_reg >= 16'(HALF_MIN_CYC - 1)) &&
                    (half_reg <= 16'(HALF_MAX_CYC - 1));
  wire win_done   = (win_reg >= 16'(WINDOW_CYC));
  wire req_hit    = (edges_reg >= 5'(REQ_EDGES));

  // command acceptance decode
  wire cmd_take    = (state_reg == S_CM_IDLE) && i_cmd_valid;
  wire level_short = i_cmd.level > o_auth_level;
  // a required flag bars its own level, so the highest unbarred level wins
  wire [1:0] auto_level = !i_mfg_auth_req ? AUTH_MFG :
                          !i_usr_auth_req ? AUTH_USER : AUTH_NONE;

  // capture boot cause once per boot, after release
  always_ff @(posedge I_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      por_boot_reg <= 1'b0;
      resume_reg   <= 1'b0;
    end else if (state_reg == S_INIT) begin
      por_boot_reg <= i_por;
      resume_reg   <= i_sleep_resume;
    end
  end

  // toggle rate measurement while request checking
  always_ff @(posedge I_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      pin_d_reg <= 1'b0;
      half_reg  <= 16'h0000;
      win_reg   <= 16'h0000;
      edges_reg <= 5'h00;
    end else if (state_reg != S_REQ_CHK) begin
      pin_d_reg <= i_config_request_pin;
      half_reg  <= 16'h0000;
      win_reg   <= 16'h0000;
      edges_reg <= 5'h00;
    end else begin
      pin_d_reg <= i_config_request_pin;
      win_reg   <= sat16(win_reg);
      half_reg  <= pin_edge ? 16'h0000 : sat16(half_reg);
      if (pin_edge) begin
        edges_reg <= half_in_bd ? edges_reg + 5'h01 : 5'h00;
      end
    end
  end

  // next state
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      S_INIT:      state_next = S_NVM_UP;
      S_NVM_UP:    if (i_nvm_ready) state_next = i_nvm_blank ? S_REQ_CHK : S_MFG_TRIM;
      S_MFG_TRIM:  state_next = S_REQ_CHK;
      S_REQ_CHK: begin
        if (!por_boot_reg) state_next = S_MFG_LOCK;
        else if (req_hit) state_next = S_CM_INIT;
        else if (win_done) state_next = S_MFG_LOCK;
      end
      S_MFG_LOCK:  state_next = i_mfg_lock.ok ? S_USR_TRIM : S_HALT;
      S_USR_TRIM:  state_next = S_USR_LOCK;
      S_USR_LOCK:  state_next = i_usr_lock.ok ? S_ENTRY : S_HALT;
      S_ENTRY:     state_next = i_entry_valid ? S_APP_VEC : S_HALT;
      S_APP_VEC:   state_next = S_APP_RET;
      S_APP_RET:   state_next = S_APP_CAUSE;
      S_APP_CAUSE: state_next = S_APP_RUN;
      S_APP_RUN:   state_next = S_APP_RUN;
      S_CM_INIT:   state_next = S_CM_ANN;
      S_CM_ANN:    state_next = S_CM_AUTH;
      S_CM_AUTH:   state_next = S_CM_IDLE;
      S_CM_IDLE:   if (i_cmd_valid) state_next = level_short ? S_CM_IDLE : S_CM_EXEC;
      S_CM_EXEC:   if (i_cmd_exec_done) state_next = S_CM_IDLE;
      S_HALT:      state_next = S_HALT;
      default:     state_next = S_HALT;
    endcase
  end

  // state register
  always_ff @(posedge I_CLK or posedge I_RESET) begin
    if (I_RESET) state_reg <= S_INIT;
    else state_reg <= state_next;
  end

  // applied trims and lock bits, reloaded each boot
  always_ff @(posedge I_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      o_trim_mfg <= 32'h00000000;
      o_trim_usr <= 32'h00000000;
      o_lock_mfg <= 32'h00000000;
      o_lock_usr <= 32'h00000000;
    end else begin
      if (state_reg == S_MFG_TRIM && i_mfg_trim.ok) o_trim_mfg <= i_mfg_trim.data;
      if (state_reg == S_MFG_LOCK && i_mfg_lock.ok) o_lock_mfg <= i_mfg_lock.data;
      if (state_reg == S_USR_TRIM && i_usr_trim.ok) o_trim_usr <= i_usr_trim.data;
      if (state_reg == S_USR_LOCK && i_usr_lock.ok) o_lock_usr <= i_usr_lock.data;
    end
  end

  // mode, debug and nvm stage outputs
  always_ff @(posedge I_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      o_debug_en           <= 1'b0;
      o_configuration_mode <= 1'b0;
      o_app_mode           <= 1'b0;
      o_nvm_stage          <= 1'b0;
      o_halt               <= 1'b0;
      o_exec_page          <= ENTRY_PAGE;
      o_vec_in_nvm         <= 1'b0;
      o_retention_cfg      <= 1'b0;
      o_resume_path        <= 1'b0;
      o_irq_mask           <= 8'hff;
    end else begin
      o_debug_en           <= (state_next == S_APP_RUN);
      o_configuration_mode <= state_next inside {S_CM_INIT, S_CM_ANN, S_CM_AUTH,
                                                 S_CM_IDLE, S_CM_EXEC};
      o_nvm_stage          <= state_next inside {S_APP_VEC, S_APP_RET, S_APP_CAUSE,
                                                 S_APP_RUN};
      o_app_mode           <= (state_next == S_APP_RUN);
      o_halt               <= (state_next == S_HALT);
      if (state_next == S_APP_VEC) o_exec_page <= ENTRY_PAGE;
      if (state_next == S_APP_RET) o_vec_in_nvm <= 1'b1;
      if (state_next == S_APP_CAUSE) o_retention_cfg <= 1'b1;
      if (state_next == S_APP_RUN) begin
        o_resume_path <= resume_reg;
        o_exec_page   <= 6'h01;
      end
      if (state_next == S_CM_INIT) o_irq_mask <= IRQ_CM_MASK;
    end
  end

  // configuration mode command loop and events
  always_ff @(posedge I_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      o_auth_level <= AUTH_NONE;
      o_cmd_ready  <= 1'b0;
      o_cmd_start  <= 1'b0;
      o_evt_valid  <= 1'b0;
      o_evt        <= '0;
      o_cpu_sleep  <= 1'b0;
    end else begin
      o_cmd_start <= 1'b0;
      o_evt_valid <= 1'b0;
      if (state_reg == S_CM_AUTH) o_auth_level <= auto_level;
      o_cmd_ready <= (state_next == S_CM_IDLE);
      o_cpu_sleep <= (state_next == S_CM_IDLE) && !i_cmd_valid &&
                     !i_task_pending;
      if (state_reg == S_CM_ANN) begin
        o_evt_valid <= 1'b1;
        o_evt       <= '{code: EVT_CM_ENTERED, status: ST_OK};
      end else if (cmd_take && level_short) begin
        o_evt_valid <= 1'b1;
        o_evt       <= '{code: EVT_CMD_DONE, status: ST_INSUFF_AUTH};
      end else if (cmd_take) begin
        o_cmd_start <= 1'b1;
      end else if (state_reg == S_CM_EXEC && i_cmd_exec_done) begin
        o_evt_valid <= 1'b1;
        o_evt       <= '{code: EVT_CMD_DONE, status: ST_OK};
      end
    end
  end

  // checks
  AST_HALT_STICKS: assert property (@(posedge I_CLK) disable iff (I_RESET)
    o_halt |=> o_halt && !o_app_mode && !o_configuration_mode)
    else $error("halt left before reset");
  AST_NO_DEBUG_IN_ROM: assert property (@(posedge I_CLK) disable iff (I_RESET)
    !o_app_mode |-> !o_debug_en)
    else $error("debug enabled in rom stage");
  AST_MFG_LOCK_HALT: assert property (@(posedge I_CLK) disable iff (I_RESET)
    (state_reg == S_MFG_LOCK && !i_mfg_lock.ok) |=> ##1 o_halt)
    else $error("bad lock bits did not halt");
  AST_USR_LOCK_HALT: assert property (@(posedge I_CLK) disable iff (I_RESET)
    (state_reg == S_USR_LOCK && !i_usr_lock.ok) |=> ##1 (o_halt && !o_app_mode))
    else $error("bad user lock bits did not halt");
  AST_MFG_TRIM_KEEP: assert property (@(posedge I_CLK) disable iff (I_RESET)
    (state_reg == S_MFG_TRIM && !i_mfg_trim.ok) |=> $stable(o_trim_mfg))
    else $error("bad trims applied");
  AST_NO_REQ_NON_POR: assert property (@(posedge I_CLK) disable iff (I_RESET)
    (state_reg == S_REQ_CHK && !por_boot_reg) |=> state_reg == S_MFG_LOCK)
    else $error("request checked after non power-on boot");
  AST_ANNOUNCE: assert property (@(posedge I_CLK) disable iff (I_RESET)
    (state_reg == S_CM_ANN) |=> o_evt_valid && o_evt.code == EVT_CM_ENTERED)
    else $error("entry event missing");
  AST_ONE_AT_A_TIME: assert property (@(posedge I_CLK) disable iff (I_RESET)
    o_cmd_start |-> !o_cmd_ready ##1 !o_cmd_start)
    else $error("command started while another runs");
  AST_AUTH_REFUSE: assert property (@(posedge I_CLK) disable iff (I_RESET)
    (cmd_take && level_short) |=> o_evt_valid && o_evt.status == ST_INSUFF_AUTH
      && !o_cmd_start)
    else $error("short level command not refused");
  AST_CM_IRQ: assert property (@(posedge I_CLK) disable iff (I_RESET)
    o_configuration_mode |-> o_irq_mask == IRQ_CM_MASK)
    else $error("interrupts not masked in configuration mode");
  AST_CM_NO_NVM: assert property (@(posedge I_CLK) disable iff (I_RESET)
    o_configuration_mode |-> !o_nvm_stage && !o_app_mode)
    else $error("nvm stage ran in configuration mode");
  AST_INIT_FIRST: assert property (@(posedge I_CLK) disable iff (I_RESET)
    (state_reg == S_INIT) |=> state_reg == S_NVM_UP)
    else $error("nvm power up did not follow init");
  AST_BLANK_SKIP: assert property (@(posedge I_CLK) disable iff (I_RESET)
    (state_reg == S_NVM_UP && i_nvm_ready && i_nvm_blank) |=> state_reg == S_REQ_CHK)
    else $error("blank chip loaded trims");
  AST_MFG_TRIM_LOAD: assert property (@(posedge I_CLK) disable iff (I_RESET)
    (state_reg == S_MFG_TRIM && i_mfg_trim.ok) |=> o_trim_mfg == $past(i_mfg_trim.data))
    else $error("good trims not applied");
  AST_REQ_OUT_OF_BAND: assert property (@(posedge I_CLK) disable iff (I_RESET)
    (state_reg == S_REQ_CHK && pin_edge && !half_in_bd) |=> edges_reg == 5'h00)
    else $error("out of band edge counted");
  AST_REQ_WINDOW: assert property (@(posedge I_CLK) disable iff (I_RESET)
    (state_reg == S_REQ_CHK && por_boot_reg && !req_hit && win_done) |=> state_reg == S_MFG_LOCK)
    else $error("request window did not close");
  AST_USR_TRIM_SKIP: assert property (@(posedge I_CLK) disable iff (I_RESET)
    (state_reg == S_USR_TRIM && !i_usr_trim.ok) |=> $stable(o_trim_usr) && state_reg == S_USR_LOCK)
    else $error("bad user trims applied or boot stopped");
  AST_ENTRY_JUMP: assert property (@(posedge I_CLK) disable iff (I_RESET)
    (state_reg == S_ENTRY && i_entry_valid) |=> o_nvm_stage && o_exec_page == ENTRY_PAGE)
    else $error("no jump to entry page");
  AST_APP_PAGE: assert property (@(posedge I_CLK) disable iff (I_RESET)
    o_app_mode |-> o_exec_page != ENTRY_PAGE)
    else $error("application runs from entry page");
  AST_VEC_FIRST: assert property (@(posedge I_CLK) disable iff (I_RESET)
    $rose(o_retention_cfg) |-> o_vec_in_nvm)
    else $error("retention set before vector table moved");
  AST_RESUME_PATH: assert property (@(posedge I_CLK) disable iff (I_RESET)
    (state_reg == S_APP_CAUSE) |=> o_resume_path == resume_reg)
    else $error("wrong nvm stage branch");
  AST_CM_NO_DEBUG: assert property (@(posedge I_CLK) disable iff (I_RESET)
    o_configuration_mode |-> !o_debug_en)
    else $error("debug enabled in configuration mode");
  AST_AUTH_SET: assert property (@(posedge I_CLK) disable iff (I_RESET)
    (state_reg == S_CM_AUTH) |=> o_auth_level == $past(auto_level) && o_cmd_ready)
    else $error("auto authentication level wrong");
  AST_NO_START_BUSY: assert property (@(posedge I_CLK) disable iff (I_RESET)
    (state_reg != S_CM_IDLE) |=> !o_cmd_start)
    else $error("command started while not idle");
  AST_DONE_EVENT: assert property (@(posedge I_CLK) disable iff (I_RESET)
    (state_reg == S_CM_EXEC && i_cmd_exec_done) |=> o_evt_valid && o_evt.status == ST_OK)
    else $error("done event missing");
  AST_SLEEP_IDLE: assert property (@(posedge I_CLK) disable iff (I_RESET)
    o_cpu_sleep |-> o_cmd_ready)
    else $error("sleep outside idle");
  AST_EVT_IN_CM: assert property (@(posedge I_CLK) disable iff (I_RESET)
    o_evt_valid |-> o_configuration_mode)
    else $error("event outside configuration mode");
  AST_HALT_QUIET: assert property (@(posedge I_CLK) disable iff (I_RESET)
    o_halt |-> !o_cmd_start && !o_evt_valid && !o_debug_en)
    else $error("activity in halt");

endmodule

// >>> dv/bcs_host_model.sv
// external host model: sends one command at a time and waits for its event
`timescale 1ns/10ps

module bcs_host_model
  import bcs_pkg::*;
(
  // clock
  input  wire logic     i_clk,
  // answers from the sequencer
  input  wire logic     i_cmd_ready,
  input  wire logic     i_cmd_start,
  input  wire logic     i_evt_valid,
  input  wire bcs_evt_t i_evt,
  // command side
  output logic          o_cmd_valid,
  output bcs_cmd_t      o_cmd,
  output logic          o_exec_done
);
  initial begin
    o_cmd_valid = 1'b0;
    o_cmd       = '0;
    o_exec_done = 1'b0;
  end

  // one command, then its event; next only after that event
  task automatic send(input logic [15:0] op, input logic [1:0] lvl, input int dly,
                      output bcs_evt_t ev, output bit started, output bit quiet,
                      output bit ok);
    int k;
    ok      = 0;
    started = 0;
    quiet   = 1;
    ev      = '0;
    @(posedge i_clk) #1;
    for (k = 0; k < 50 && i_cmd_ready !== 1'b1; k++) @(posedge i_clk) #1;
    o_cmd       = '{opcode: op, level: lvl};
    o_cmd_valid = 1'b1;
    @(posedge i_clk) #1;
    o_cmd_valid = 1'b0;
    o_cmd       = ~o_cmd; // released lines do not keep the old value
    for (k = 0; k < 10 && i_cmd_start !== 1'b1 && i_evt_valid !== 1'b1; k++) @(posedge i_clk) #1;
    if (i_evt_valid === 1'b1) begin
      ev = i_evt;
      ok = 1;
    end else if (i_cmd_start === 1'b1) begin
      started = 1;
      repeat (dly) begin
        @(posedge i_clk) #1;
        if (i_cmd_ready !== 1'b0) quiet = 0;
      end
      o_exec_done = 1'b1;
      @(posedge i_clk) #1;
      o_exec_done = 1'b0;
      for (k = 0; k < 10 && i_evt_valid !== 1'b1; k++) @(posedge i_clk) #1;
      ev = i_evt;
      ok = (i_evt_valid === 1'b1);
    end
  endtask
endmodule

// >>> dv/bcs_sequencer_test.sv
// self-checking testbench for the boot and configuration mode sequencer
`timescale 1ns/10ps

module bcs_sequencer_test;
  import bcs_pkg::*;

  localparam int unsigned WIN = 3300;
  localparam logic [31:0] D_MT = 32'h1a2b_0001;
  localparam logic [31:0] D_ML = 32'h3c4d_0002;
  localparam logic [31:0] D_UT = 32'h5e6f_0003;
  localparam logic [31:0] D_UL = 32'h7a8b_0004;

  logic        clk, rst, por, slp, mreq, ureq, pin, tpend, cmd_valid, exec_done;
  logic        cmd_ready, cmd_start, evt_valid, debug_en, cfg_mode, app_mode, nvm_stage;
  logic        halt, cpu_sleep, vec_nvm, ret_cfg, resume;
  bcs_rec_t    mt, ml, ut, ul;
  bcs_cmd_t    cmd;
  bcs_evt_t    evt, last_evt, ev;
  logic [31:0] tr_m, tr_u, lk_m, lk_u;
  logic [7:0]  irq_mask;
  logic [1:0]  auth;
  logic [5:0]  page;
  int          failures, samples_checked, half_cyc, tcnt;
  bit          dbg_early, started, quiet, ok;
  logic        entry, blank;

  bcs_sequencer #(.WINDOW_CYC(WIN)) DUT (
    .I_CLK(clk), .I_RESET(rst), .i_por(por), .i_sleep_resume(slp), .i_nvm_ready(1'b1),
    .i_nvm_blank(blank), .i_mfg_trim(mt), .i_mfg_lock(ml), .i_usr_trim(ut), .i_usr_lock(ul),
    .i_entry_valid(entry), .i_mfg_auth_req(mreq), .i_usr_auth_req(ureq),
    .i_config_request_pin(pin), .i_cmd_valid(cmd_valid), .i_cmd(cmd),
    .i_cmd_exec_done(exec_done), .i_task_pending(tpend), .o_cmd_ready(cmd_ready),
    .o_cmd_start(cmd_start), .o_evt_valid(evt_valid), .o_evt(evt), .o_trim_mfg(tr_m),
    .o_trim_usr(tr_u), .o_lock_mfg(lk_m), .o_lock_usr(lk_u), .o_debug_en(debug_en),
    .o_configuration_mode(cfg_mode), .o_app_mode(app_mode), .o_nvm_stage(nvm_stage),
    .o_halt(halt), .o_cpu_sleep(cpu_sleep), .o_irq_mask(irq_mask), .o_auth_level(auth),
    .o_exec_page(page), .o_vec_in_nvm(vec_nvm), .o_retention_cfg(ret_cfg),
    .o_resume_path(resume));

  bcs_host_model host (
    .i_clk(clk), .i_cmd_ready(cmd_ready), .i_cmd_start(cmd_start), .i_evt_valid(evt_valid),
    .i_evt(evt), .o_cmd_valid(cmd_valid), .o_cmd(cmd), .o_exec_done(exec_done));

  // clock and request pin toggler at the chosen half period
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    pin  = 1'b0;
    tcnt = 0;
    forever begin
      @(posedge clk) #1;
      tcnt++;
      if (half_cyc != 0 && tcnt >= half_cyc) begin
        pin  = ~pin;
        tcnt = 0;
      end
    end
  end

  task automatic end_sim();
    $display("checks %0d, mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // reset for 4 cycles, then wait until the boot settles
  task automatic boot(input logic p, s, a, b, c, d, input int half);
    int k;
    @(posedge clk) #1;
    rst = 1'b1;
    {por, slp, half_cyc} = {p, s, half};
    mt = '{D_MT, a};
    ml = '{D_ML, b};
    ut = '{D_UT, c};
    ul = '{D_UL, d};
    repeat (4) @(posedge clk);
    #1 rst = 1'b0;
    last_evt  = '0;
    dbg_early = 0;
    for (k = 0; k < 8000; k++) begin
      @(posedge clk) #1;
      if (evt_valid === 1'b1) last_evt = evt;
      if (debug_en === 1'b1 && app_mode !== 1'b1) dbg_early = 1;
      if (app_mode === 1'b1 || halt === 1'b1 || cmd_ready === 1'b1) break;
    end
    if (k == 8000) begin
      failures++;
      end_sim();
    end
  endtask

  task automatic send(input logic [15:0] op, input logic [1:0] lvl, input int dly);
    host.send(op, lvl, dly, ev, started, quiet, ok);
    if (!ok) begin
      failures++;
      end_sim();
    end
  endtask

  task automatic wait_sleep(input logic exp);
    int k;
    for (k = 0; k < 20 && cpu_sleep !== exp; k++) @(posedge clk) #1;
    chk(cpu_sleep, exp);
  endtask

  task automatic t_app();
    boot(1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 333);
    chk(app_mode, 1'b1);
    chk(cfg_mode, 1'b0);
    chk({tr_m ^ D_MT, tr_u ^ D_UT}, '0);
    chk({lk_m ^ D_ML, lk_u ^ D_UL}, '0);
    chk({debug_en, dbg_early}, 2'h2);
    chk({page, vec_nvm, ret_cfg, resume}, 9'h00e);
    $display("test t_app done");
  endtask

  task automatic t_entry();
    entry = 1'b0;
    boot(1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 0);
    chk({halt, app_mode}, 2'h2);
    entry = 1'b1;
    blank = 1'b1;
    boot(1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 0);
    chk({app_mode, tr_m}, {1'b1, 32'h0});
    blank = 1'b0;
    $display("test t_entry done");
  endtask

  task automatic t_trim_fault();
    boot(1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 0);
    chk(app_mode, 1'b1);
    chk({tr_m, tr_u}, '0);
    chk({lk_m, lk_u}, {D_ML, D_UL});
    chk(resume, 1'b1);
    $display("test t_trim_fault done");
  endtask

  task automatic t_lock_fault();
    for (int i = 0; i < 2; i++) begin
      boot(1'b0, 1'b0, 1'b1, i == 1, 1'b1, i == 0, 0);
      chk(halt, 1'b1);
      chk(i == 0 ? lk_m : lk_u, '0);
      repeat (50) @(posedge clk);
      #1 chk({halt, app_mode, debug_en, nvm_stage}, 4'h8);
    end
    $display("test t_lock_fault done");
  endtask

  task automatic t_band();
    boot(1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 167);
    chk({cfg_mode, app_mode}, 2'h1);
    $display("test t_band done");
  endtask

  task automatic t_cfg();
    mreq = 1'b0;
    boot(1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 333);
    chk(auth, AUTH_MFG);
    mreq = 1'b1;
    boot(1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 333);
    half_cyc = 0;
    chk({cfg_mode, app_mode, nvm_stage, debug_en}, 4'h8);
    chk(last_evt.code, EVT_CM_ENTERED);
    chk(irq_mask, IRQ_CM_MASK);
    chk(auth, AUTH_USER);
    send(FULL_ERASE_CMD, AUTH_MFG, 5);
    chk({ev, 1'b0 + started}, {EVT_CMD_DONE, ST_INSUFF_AUTH, 1'b0});
    send(16'h0001, AUTH_NONE, 20);
    chk({ev, 1'b0 + started, 1'b0 + quiet}, {EVT_CMD_DONE, ST_OK, 2'h3});
    send(16'h0002, AUTH_USER, 0);
    chk({ev, 1'b0 + started}, {EVT_CMD_DONE, ST_OK, 1'b1});
    wait_sleep(1'b1);
    tpend = 1'b1;
    wait_sleep(1'b0);
    tpend = 1'b0;
    ureq = 1'b1;
    boot(1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 333);
    half_cyc = 0;
    chk(auth, AUTH_NONE);
    send(16'h0003, AUTH_USER, 0);
    chk({ev, 1'b0 + started}, {EVT_CMD_DONE, ST_INSUFF_AUTH, 1'b0});
    ureq = 1'b0;
    $display("test t_cfg done");
  endtask

  initial begin
    {rst, por, slp, mreq, ureq, tpend} = 6'h20;
    {entry, blank} = 2'h2;
    {mt, ml, ut, ul} = '0;
    {failures, samples_checked, half_cyc} = '0;
    t_app();
    t_entry();
    t_trim_fault();
    t_lock_fault();
    t_band();
    t_cfg();
    end_sim();
  end
endmodule
